/* hdl/vmci_pkg.sv */
// Package for the video-mode command inserter.
// Assumes one 20 MHz lane-side clock and an APB slave port.
package vmci_pkg;
    // Register byte offsets
    localparam logic [11:0] LPC_TIMING_OFF = 12'h018;
    localparam logic [11:0] VID_MODE_OFF   = 12'h038;
    localparam logic [11:0] PHY_TMR_OFF    = 12'h09C;
    localparam logic [11:0] STATUS_OFF     = 12'h1F0;
    // Field positions
    localparam int OUTVACT_LSB  = 16;
    localparam int INVACT_LSB   = 0;
    localparam int LPCMDEN_BIT  = 15;
    localparam int FRAME_TA_BIT = 14;
    localparam int MAX_RD_LSB   = 0;
    // Reset values
    localparam logic [7:0]  BUDGET_RST = 8'h00;
    localparam logic [14:0] MAX_RD_RST = 15'h0000;
    // Short packet bytes and escape cycles per low-power byte
    localparam logic [7:0]  SHORT_BYTES = 8'h04;
    localparam int          LP_BITS     = 8;
    localparam int          ESC_PER_BIT = 2;
    localparam logic [11:0] ESC_PER_BYTE = 12'(LP_BITS * ESC_PER_BIT);
    // Video regions
    typedef enum logic [1:0] {
        REG_VSA, REG_VBP, REG_VFP, REG_VACT
    } vmci_region_t;
    // Display-control packet kinds
    typedef enum logic [1:0] {
        DC_COLOR_ON, DC_COLOR_OFF, DC_SHUT_DOWN, DC_TURN_ON
    } vmci_dcp_t;
    // APB request and answer
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } vmci_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } vmci_apb_rsp_t;
    // Video timing from the packet handler
    typedef struct packed {
        logic         video_mode;
        logic         slot_open;
        logic         line_start;
        logic         last_line;
        logic         frame_end;
        vmci_region_t region;
        logic [15:0]  slot_cycles;
    } vmci_vid_t;
    // Head of the generic command queue
    typedef struct packed {
        logic       valid;
        logic       read;
        logic [7:0] size;
    } vmci_cmd_t;
    // Command launch to the packet builder
    typedef struct packed {
        logic        valid;
        logic        lp;
        logic        dcp;
        logic        read;
        vmci_dcp_t   kind;
        logic [7:0]  size;
    } vmci_send_t;
endpackage

/* hdl/vmci_inserter.sv */
// Video-mode command inserter: picks a slot per line for one command.
// Assumes timing, queue and done inputs come from logic on sys_clk;
// pins and the escape clock are asynchronous and are synchronised here.
//
// What this block does
// - Commands go only in open video-mode slots
// - Slots follow VSS, HSE, HSS, HACT events
// - At most one command per line
// - No writes or pin packets in the last frame line
// - Pin changes issue display-control packets
// - Display-control packets never in vertical active
// - LP display-control uses blanking budget, four bytes
// - Frame-end turnaround holds halt until acknowledge
// - LP enable sends commands low power with budgets
// - LP disable sends high speed, no budgets
// - Blanking LP command fits outside budget
// - Active LP command fits inside budget
// - Max read time judges read fit
// - Unfitting reads deferred to last line, halt
// - Budget fields at bits 23:16 and 7:0
`timescale 1ns/1ns
module vmci_inserter (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // APB register port
    input  wire vmci_pkg::vmci_apb_req_t apb_req,
    output      vmci_pkg::vmci_apb_rsp_t apb_rsp,
    // Video timing and queue head
    input  wire vmci_pkg::vmci_vid_t    vid,
    input  wire vmci_pkg::vmci_cmd_t    cmd,
    output      logic                   cmd_take,
    // Launch and completion
    output      vmci_pkg::vmci_send_t   send,
    input  wire logic                   tx_done,
    // Turnaround and halt
    output      logic                   bta_req,
    input  wire logic                   bta_ack,
    output      logic                   halt,
    // Asynchronous pins and escape clock
    input  wire logic                   colorm_pin,
    input  wire logic                   shutdn_pin,
    input  wire logic                   esc_clk
);
    import vmci_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // State
    typedef enum logic [1:0] {ST_IDLE, ST_LP, ST_WAIT, ST_TURN} vmci_st_t;

    typedef struct packed {
        vmci_st_t      st;        // Launch state
        logic          line_used; // A command went in this line
        logic          bta_pend;  // Turnaround owed at frame end
        logic [1:0]    sync1;     // Pin synchroniser stage one
        logic [1:0]    sync2;     // Pin synchroniser stage two
        logic [1:0]    seen;      // Stage-two pin levels one cycle back
        logic [1:0]    dpend;     // Pending pin packets
        logic          esc1;      // Escape clock stage one
        logic          esc2;      // Escape clock stage two
        logic          esc3;      // Escape clock edge history
        logic [11:0]   esc_cnt;   // Escape edges left in LP send
        logic [7:0]    outvact;   // Blanking-line LP budget
        logic [7:0]    invact;    // Active-region LP budget
        logic          lpcmden;   // Low-power command enable
        logic          frame_ta;  // Frame-end turnaround enable
        logic [14:0]   max_rd;    // Max read time, byte clocks
        vmci_apb_rsp_t rsp;       // APB answer
        vmci_send_t    send;      // Launch output
        logic          cmd_take;  // Queue pop
        logic          bta_req;   // Turnaround request
        logic          halt;      // Halt output
    } vmci_state_t;

    vmci_state_t s;       // Registered state
    vmci_state_t next_s;  // Next state

    ////////////////////////////////////////////////////////////////////
    // Outputs straight from flops
    assign apb_rsp  = s.rsp;
    assign send     = s.send;
    assign cmd_take = s.cmd_take;
    assign bta_req  = s.bta_req;
    assign halt     = s.halt;

    ////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic        used;     // Line already carries a command
        logic        blank;    // Slot lies outside vertical active
        logic [7:0]  budget;   // LP budget for this slot
        logic        gen_fit;  // Queue head fits this slot
        logic        dc_ok;    // Pin packet may go now
        logic        gen_ok;   // Queue head may go now
        logic        esc_edge; // Rising escape clock edge
        logic        hit;      // APB address is mapped
        logic [31:0] rdata;    // APB read value
        next_s = s;
        used     = 1'b0;
        blank    = 1'b0;
        budget   = 8'h00;
        gen_fit  = 1'b0;
        dc_ok    = 1'b0;
        gen_ok   = 1'b0;
        esc_edge = 1'b0;
        hit      = 1'b0;
        rdata    = 32'h0000_0000;
        // One-cycle pulses default low
        next_s.send.valid  = 1'b0;
        next_s.cmd_take    = 1'b0;
        next_s.bta_req     = 1'b0;
        next_s.rsp.pready  = 1'b0;
        next_s.rsp.pslverr = 1'b0;
        // Synchronisers; only stage two is read
        next_s.sync1 = {shutdn_pin, colorm_pin};
        next_s.sync2 = s.sync1;
        next_s.seen  = s.sync2;
        next_s.esc1  = esc_clk;
        next_s.esc2  = s.esc1;
        next_s.esc3  = s.esc2;
        esc_edge = s.esc2 & ~s.esc3;
        // Line bookkeeping
        used = vid.line_start ? 1'b0 : s.line_used;
        if (vid.line_start) begin
            next_s.line_used = 1'b0;
        end
        blank  = (vid.region != REG_VACT);
        budget = blank ? s.outvact : s.invact;
        // Fit of the queue head: budget in LP, read time always
        gen_fit = (!s.lpcmden || (cmd.size <= budget))
                && (!cmd.read
                    || ({1'b0, s.max_rd} <= vid.slot_cycles));
        // Pin packets: blanking only, not last line, LP needs 4 bytes
        dc_ok = (s.dpend != 2'b00) && blank && !vid.last_line
              && (!s.lpcmden || (s.outvact >= SHORT_BYTES));
        // Last line only takes deferred reads
        gen_ok = cmd.valid && (vid.last_line ? cmd.read
                                             : gen_fit);
        // Launch state machine
        case (s.st)
            ST_IDLE: begin
                if (s.bta_pend) begin
                    next_s.bta_pend = 1'b0;
                    next_s.bta_req  = 1'b1;
                    next_s.halt     = 1'b1;
                    next_s.st       = ST_TURN;
                end else if (vid.video_mode && vid.slot_open
                             && !used) begin
                    if (dc_ok) begin
                        // Shut-down pin beats colour pin
                        next_s.send.valid = 1'b1;
                        next_s.send.lp    = s.lpcmden;
                        next_s.send.dcp   = 1'b1;
                        next_s.send.read  = 1'b0;
                        next_s.send.size  = SHORT_BYTES;
                        if (s.dpend[1]) begin
                            next_s.dpend[1]  = 1'b0;
                            next_s.send.kind = s.sync2[1] ?
                                DC_SHUT_DOWN : DC_TURN_ON;
                        end else begin
                            next_s.dpend[0]  = 1'b0;
                            next_s.send.kind = s.sync2[0] ?
                                DC_COLOR_ON : DC_COLOR_OFF;
                        end
                        next_s.line_used = 1'b1;
                        next_s.esc_cnt   = 12'(SHORT_BYTES * ESC_PER_BYTE);
                        next_s.st = s.lpcmden ? ST_LP : ST_WAIT;
                    end else if (gen_ok) begin
                        next_s.send.valid = 1'b1;
                        next_s.send.lp    = s.lpcmden;
                        next_s.send.dcp   = 1'b0;
                        next_s.send.read  = cmd.read;
                        next_s.send.kind  = DC_COLOR_ON;
                        next_s.send.size  = cmd.size;
                        next_s.cmd_take   = 1'b1;
                        next_s.line_used  = 1'b1;
                        next_s.halt       = vid.last_line;
                        next_s.esc_cnt    = 12'(cmd.size * ESC_PER_BYTE);
                        next_s.st = (s.lpcmden && !cmd.read) ?
                                    ST_LP : ST_WAIT;
                    end
                    // Otherwise the head stays queued for later
                end
            end
            ST_LP: begin
                // LP write lasts 16 escape cycles per byte
                if (esc_edge) begin
                    next_s.esc_cnt = s.esc_cnt - 12'h001;
                    if (s.esc_cnt <= 12'h001) begin
                        next_s.st = ST_IDLE;
                    end
                end
            end
            ST_WAIT: begin
                // HS sends and reads end on the builder's done
                if (tx_done) begin
                    next_s.halt = 1'b0;
                    next_s.st   = ST_IDLE;
                end
            end
            ST_TURN: begin
                // Halt holds until the peripheral hands back the bus
                if (bta_ack) begin
                    next_s.halt = 1'b0;
                    next_s.st   = ST_IDLE;
                end
            end
            default: begin
                next_s.st = ST_IDLE;
            end
        endcase
        // Pin changes set pending; the set wins over a clear
        for (int i = 0; i < 2; i++) begin
            if (s.sync2[i] != s.seen[i]) begin
                next_s.dpend[i] = 1'b1;
            end
        end
        // Frame end owes a turnaround when enabled
        if (vid.frame_end && s.frame_ta) begin
            next_s.bta_pend = 1'b1;
        end
        // APB decode
        case (apb_req.paddr)
            LPC_TIMING_OFF: begin
                hit = 1'b1;
                rdata[OUTVACT_LSB +: 8] = s.outvact;
                rdata[INVACT_LSB +: 8]  = s.invact;
            end
            VID_MODE_OFF: begin
                hit = 1'b1;
                rdata[LPCMDEN_BIT]  = s.lpcmden;
                rdata[FRAME_TA_BIT] = s.frame_ta;
            end
            PHY_TMR_OFF: begin
                hit = 1'b1;
                rdata[MAX_RD_LSB +: 15] = s.max_rd;
            end
            STATUS_OFF: begin
                hit = 1'b1;
                rdata[1:0] = s.st;
                rdata[2]   = s.line_used;
                rdata[3]   = s.bta_pend;
                rdata[5:4] = s.dpend;
                rdata[6]   = s.halt;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        // APB: answer one cycle into access; write at the ready edge
        if (apb_req.psel && apb_req.penable) begin
            if (!s.rsp.pready) begin
                next_s.rsp.pready  = 1'b1;
                next_s.rsp.pslverr = !hit;
                next_s.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000
                                                    : rdata;
            end else if (apb_req.pwrite) begin
                case (apb_req.paddr)
                    LPC_TIMING_OFF: begin
                        next_s.outvact =
                            apb_req.pwdata[OUTVACT_LSB +: 8];
                        next_s.invact = apb_req.pwdata[INVACT_LSB +: 8];
                    end
                    VID_MODE_OFF: begin
                        next_s.lpcmden  = apb_req.pwdata[LPCMDEN_BIT];
                        next_s.frame_ta = apb_req.pwdata[FRAME_TA_BIT];
                    end
                    PHY_TMR_OFF: begin
                        next_s.max_rd = apb_req.pwdata[MAX_RD_LSB +: 15];
                    end
                    default: begin
                        next_s.max_rd = s.max_rd;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s         <= '0;
            s.st      <= ST_IDLE;
            s.outvact <= BUDGET_RST;
            s.invact  <= BUDGET_RST;
            s.max_rd  <= MAX_RD_RST;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    slot_only_a: assert property (s.send.valid |->
        $past(vid.video_mode) && $past(vid.slot_open))
        else $error("Launch outside a video slot");
    one_per_line_a: assert property (s.send.valid |->
        ($past(vid.line_start) || !$past(s.line_used)))
        else $error("Second command in one line");
    no_last_line_a: assert property (
        s.send.valid && !s.send.read |-> !$past(vid.last_line))
        else $error("Write sent in last line");
    dcp_vact_a: assert property (
        s.send.valid && s.send.dcp |-> $past(vid.region) != REG_VACT)
        else $error("Pin packet in vertical active");
    dcp_lp_a: assert property (
        s.send.valid && s.send.dcp && $past(s.lpcmden) |->
        s.send.lp && $past(s.outvact) >= SHORT_BYTES)
        else $error("Pin packet LP budget broken");
    mode_follow_a: assert property (
        s.send.valid |-> s.send.lp == $past(s.lpcmden))
        else $error("Signalling mode wrong");
    blank_budget_a: assert property (
        s.send.valid && s.send.lp && !$past(vid.last_line)
        && $past(vid.region) != REG_VACT |->
        s.send.size <= $past(s.outvact))
        else $error("Blanking budget exceeded");
    vact_budget_a: assert property (
        s.send.valid && s.send.lp && $past(vid.region) == REG_VACT |->
        s.send.size <= $past(s.invact))
        else $error("Active budget exceeded");
    read_fit_a: assert property (
        s.send.valid && s.send.read && !$past(vid.last_line) |->
        {1'b0, $past(s.max_rd)} <= $past(vid.slot_cycles))
        else $error("Read sent without time");
    halt_hold_a: assert property (
        s.bta_req |-> s.halt ##1 (s.halt throughout
        (s.st == ST_TURN && !bta_ack)[*1]))
        else $error("Halt dropped before acknowledge");
    lp_length_a: assert property (
        s.send.valid && s.send.lp && !s.send.read |->
        s.esc_cnt == 12'(s.send.size * ESC_PER_BYTE))
        else $error("LP duration wrong");

    dcp_seen_c: cover property (s.send.valid && s.send.dcp);
    lp_write_c: cover property (s.send.valid && s.send.lp);
    defer_read_c: cover property (s.send.valid && s.send.read && s.halt);
    turn_c: cover property (s.st == ST_TURN ##1 s.st == ST_IDLE);
endmodule

/* sim/vmci_periph_model.sv */
// Peripheral model facing the video-mode command inserter.
// Assumes launches and turnaround requests arrive on sys_clk.
`timescale 1ns/1ns
module vmci_periph_model (
    // Clock, reset and pace
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 slow,
    // From the inserter
    input  wire vmci_pkg::vmci_send_t send,
    input  wire logic                 bta_req,
    // Back to the inserter
    output      logic                 tx_done,
    output      logic                 bta_ack
);
    import vmci_pkg::*;
    int tx_cnt;  // Cycles left in a send
    int ta_cnt;  // Cycles left holding the bus
    int pace;    // Answer delay, prompt or slow
    always_comb pace = slow ? 40 : 3;
    ////////////////////////////////////////////////////////////////////
    // HS sends and reads end after the pace; the bus comes back after the pace too
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_cnt  <= 0;
            ta_cnt  <= 0;
            tx_done <= 1'b0;
            bta_ack <= 1'b0;
        end else begin
            tx_done <= (tx_cnt == 1);
            bta_ack <= (ta_cnt == 1);
            if (send.valid && (!send.lp || send.read))
                tx_cnt <= pace;
            else if (tx_cnt > 0)
                tx_cnt <= tx_cnt - 1;
            if (bta_req)
                ta_cnt <= pace;
            else if (ta_cnt > 0)
                ta_cnt <= ta_cnt - 1;
        end
    end
endmodule

/* sim/test_video_mode_command_inserter.sv */
// Bench for the video-mode command inserter.
// Assumes the package, design and peripheral model compile first.
`timescale 1ns/1ns
module test_video_mode_command_inserter;
    import vmci_pkg::*;
    logic          sys_clk    = 1'b0; // Lane-side clock
    logic          rst        = 1'b1; // Synchronous reset
    logic          esc_clk    = 1'b0; // Escape clock
    vmci_apb_req_t apb_req    = '0;   // Bus request
    vmci_apb_rsp_t apb_rsp;           // Bus answer
    vmci_vid_t     vid        = '0;   // Video timing
    vmci_cmd_t     cmd        = '0;   // Queue head
    vmci_send_t    send;              // Launch
    logic          cmd_take;          // Queue pop
    logic          tx_done;           // Send finished
    logic          bta_req;           // Turnaround asked
    logic          bta_ack;           // Bus returned
    logic          halt;              // Halt output
    logic          colorm_pin = 1'b0; // Colour mode pin
    logic          shutdn_pin = 1'b0; // Shut-down pin
    logic          slow       = 1'b0; // Peripheral pace
    logic          lp_on      = 1'b0; // Expected signalling
    logic [31:0]   rd;                // Last read data
    logic          err;               // Last error flag
    int            n_mismatch = 0;
    int            num_checks = 0;
    int            i;
    logic          sd_seq [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    logic          cm_seq [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    vmci_dcp_t     kinds  [4] = '{DC_SHUT_DOWN, DC_COLOR_ON,
                                  DC_COLOR_OFF, DC_TURN_ON};
    always #25 sys_clk = ~sys_clk;
    always #200 esc_clk = ~esc_clk;
    vmci_inserter dut (.sys_clk(sys_clk), .rst(rst), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .vid(vid), .cmd(cmd), .cmd_take(cmd_take),
        .send(send), .tx_done(tx_done), .bta_req(bta_req),
        .bta_ack(bta_ack), .halt(halt), .colorm_pin(colorm_pin),
        .shutdn_pin(shutdn_pin), .esc_clk(esc_clk));
    vmci_periph_model peer (.sys_clk(sys_clk), .rst(rst), .slow(slow),
        .send(send), .bta_req(bta_req), .tx_done(tx_done),
        .bta_ack(bta_ack));
    ////////////////////////////////////////////////////////////////////
    // Verdict and comparison
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic tmo;
        n_mismatch++;
        $display("[FAIL] %0t wait ran out", $time);
        stop_test();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    // One register transfer, held until pready is sampled
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge sys_clk);
            if (apb_rsp.pready === 1'b1) break;
        end
        if (k == 20) tmo();
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
    endtask
    // Polls the status state field until idle
    task automatic wait_idle;
        int k;
        for (k = 0; k < 400; k++) begin
            apb(1'b0, STATUS_OFF, 32'h0);
            if (rd[1:0] === 2'b00) break;
        end
        if (k == 400) tmo();
    endtask
    task automatic wait_hi(ref logic s);
        int k;
        for (k = 0; k < 100; k++) begin
            @(posedge sys_clk);
            #1;
            if (s === 1'b1) break;
        end
        if (k == 100) tmo();
    endtask
    // Opens one slot with a given head; checks launch and its mode
    task automatic try(input vmci_region_t r, input logic last,
                       input logic nl, input logic [7:0] sz,
                       input logic rdc, input logic exp);
        @(posedge sys_clk);
        vid.region <= r;
        vid.last_line <= last;
        vid.line_start <= nl;
        cmd <= '{sz != 8'h00, rdc, sz};
        @(posedge sys_clk);
        vid.line_start <= 1'b0;
        vid.slot_open <= 1'b1;
        @(posedge sys_clk);
        vid.slot_open <= 1'b0;
        #1;
        chk(send.valid, exp);
        chk(cmd_take, exp && sz != 8'h00);
        if (exp) begin
            chk(halt, last);
            if (!last) chk(send.lp, lp_on);
            cmd <= '0;
            wait_idle();
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        vid.video_mode <= 1'b1;
        vid.slot_cycles <= 16'h00C8;
        apb(1'b0, LPC_TIMING_OFF, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, LPC_TIMING_OFF, 32'h0004_0008);
        apb(1'b0, LPC_TIMING_OFF, 32'h0);
        chk(rd, 32'h0004_0008);
        apb(1'b1, PHY_TMR_OFF, 32'h0000_0064);
        // High speed: one per line, no budgets, reads need room
        try(REG_VSA, 1'b0, 1'b1, 8'h0A, 1'b0, 1'b1);
        try(REG_VSA, 1'b0, 1'b0, 8'h0A, 1'b0, 1'b0);
        try(REG_VBP, 1'b0, 1'b1, 8'hC8, 1'b0, 1'b1);
        vid.slot_cycles <= 16'h0063;
        try(REG_VFP, 1'b0, 1'b1, 8'h04, 1'b1, 1'b0);
        vid.slot_cycles <= 16'h0064;
        try(REG_VFP, 1'b0, 1'b1, 8'h04, 1'b1, 1'b1);
        try(REG_VSA, 1'b1, 1'b1, 8'h04, 1'b0, 1'b0);
        // Low power against the two budgets
        apb(1'b1, VID_MODE_OFF, 32'h0000_8000);
        lp_on = 1'b1;
        try(REG_VBP, 1'b0, 1'b1, 8'h05, 1'b0, 1'b0);
        try(REG_VBP, 1'b0, 1'b1, 8'h04, 1'b0, 1'b1);
        try(REG_VACT, 1'b0, 1'b1, 8'h09, 1'b0, 1'b0);
        try(REG_VACT, 1'b0, 1'b1, 8'h08, 1'b0, 1'b1);
        // LP read with a read time that covers both transitions
        apb(1'b1, PHY_TMR_OFF, 32'h0000_0050);
        try(REG_VBP, 1'b0, 1'b1, 8'h04, 1'b1, 1'b1);
        // Pin changes give the four display-control packets
        for (i = 0; i < 4; i++) begin
            shutdn_pin <= sd_seq[i];
            colorm_pin <= cm_seq[i];
            repeat (5) @(posedge sys_clk);
            try(REG_VACT, 1'b0, 1'b1, 8'h00, 1'b0, 1'b0);
            try(REG_VSA, 1'b0, 1'b1, 8'h00, 1'b0, 1'b1);
            chk(send.dcp, 1'b1);
            chk(send.kind, kinds[i]);
        end
        // Frame-end turnaround with a slow peripheral
        apb(1'b1, VID_MODE_OFF, 32'h0000_4000);
        lp_on = 1'b0;
        slow <= 1'b1;
        @(posedge sys_clk);
        vid.frame_end <= 1'b1;
        @(posedge sys_clk);
        vid.frame_end <= 1'b0;
        wait_hi(bta_req);
        chk(halt, 1'b1);
        wait_hi(bta_ack);
        chk(halt, 1'b1);
        repeat (3) @(posedge sys_clk);
        #1;
        chk(halt, 1'b0);
        slow <= 1'b0;
        apb(1'b1, PHY_TMR_OFF, 32'h0000_7FFF);
        try(REG_VFP, 1'b1, 1'b1, 8'h04, 1'b1, 1'b1);
        apb(1'b1, PHY_TMR_OFF, 32'h0000_0064);
        apb(1'b0, PHY_TMR_OFF, 32'h0);
        chk(rd, 32'h0000_0064);
        stop_test();
    end
endmodule
